// file: core/alwb_defines.vh
// Purpose: constants for the auto level and white balance control block
// Assumes: 20 MHz clock, APB register access with 32-bit data
// Notes:   damping factor is raw/1024, balance ratios are unsigned 2.8 fixed point
`ifndef ALWB_DEFINES_VH
`define ALWB_DEFINES_VH
`define ALWB_ADDR_CTRL       12'h000
`define ALWB_ADDR_DAMP       12'h004
`define ALWB_ADDR_TARGET     12'h008
`define ALWB_ADDR_EXP_LIM    12'h00C
`define ALWB_ADDR_GAIN_LIM   12'h010
`define ALWB_ADDR_STAT_GRAY  12'h014
`define ALWB_ADDR_STAT_RB    12'h018
`define ALWB_ADDR_EXP_GAIN   12'h01C
`define ALWB_ADDR_RATIOS     12'h020
`define ALWB_ADDR_STATUS     12'h024
`define ALWB_MODE_OFF        2'h0
`define ALWB_MODE_ONCE       2'h1
`define ALWB_MODE_CONT       2'h2
`define ALWB_CTRL_EXP_LSB    0
`define ALWB_CTRL_GAIN_LSB   2
`define ALWB_CTRL_AWB_LSB    4
`define ALWB_CTRL_MIN_BIT    6
`define ALWB_CTRL_BIT12      7
`define ALWB_CTRL_RST_CTRL   32'h0000_0000
`define ALWB_CTRL_RST_FACT   32'h0000_0002
`define ALWB_DAMP_RST        10'h2_BC
`define ALWB_DAMP_MAX        10'h3_20
`define ALWB_DAMP_SHIFT      10
`define ALWB_RATIO_INIT      10'h1_80
`define ALWB_RATIO_MAX       10'h3_FF
`define ALWB_RATIO_MIN       10'h0_00
`define ALWB_RATIO_STEP      10'h0_01
`define ALWB_TGT8_MIN        12'h0_32
`define ALWB_TGT8_MAX        12'h0_CD
`define ALWB_TGT12_MIN       12'h3_20
`define ALWB_TGT12_MAX       12'hC_D0
`define ALWB_TGT_RST         12'h0_80
`define ALWB_EXP_LO_RST      16'h0_064
`define ALWB_EXP_HI_RST      16'hF_FFF
`define ALWB_GAIN_LO_RST     16'h0_000
`define ALWB_GAIN_HI_RST     16'h0_3FF
`endif

// file: core/alwb_step.v
// Purpose: one damped control step toward a target, clamped to limits
// Assumes: damping factor raw/1024, error scaled by gain per count
// Notes:   combinational, a nonzero error moves at least one count unless the damping factor is zero
`timescale 1ns/10ps
`include "alwb_defines.vh"
module alwb_step (
   input  wire [15:0] i_cur,
   input  wire [12:0] i_err,
   input  wire        i_err_neg,
   input  wire [9:0]  i_damp,
   input  wire [15:0] i_lo,
   input  wire [15:0] i_hi,
   output reg  [15:0] o_next
);
   reg [22:0] prod;
   reg [16:0] delta;
   reg [17:0] sum;
   always @* begin
      prod  = i_err * i_damp;
      delta = {4'h0, prod[22:`ALWB_DAMP_SHIFT]};
      if (delta == 17'h0_0000 && i_err != 13'h0_000 && i_damp != 10'h000)
         delta = 17'h0_0001;
      if (i_err_neg)
         sum = (delta > {1'b0, i_cur}) ? 18'h0_0000 : {2'b00, i_cur} - {1'b0, delta};
      else
         sum = {2'b00, i_cur} + {1'b0, delta};
      if (sum < {2'b00, i_lo})
         o_next = i_lo;
      else if (sum > {2'b00, i_hi})
         o_next = i_hi;
      else
         o_next = sum[15:0];
   end
endmodule

// file: core/alwb_top.v
// Purpose: auto exposure, auto gain and auto white balance control with APB registers
// Assumes: frame statistics arrive with a one-cycle I_STAT_VALID pulse per frame
// Notes:   I_COLOR strap selects whether white balance exists; I_FACTORY_START picks startup set
`timescale 1ns/10ps
`include "alwb_defines.vh"
// Summary of operation
// - damping factor sets loop speed whenever auto exposure or auto gain runs
// - with damping the target is approached over several frames, not at once
// - after reset the damping factor holds 0.6836
// - damping factor accepts 0.0 to 0.78125; other writes are refused
// - larger damping factor moves more per frame, reaching target sooner
// - with both auto modes on, selector decides whether gain or exposure stays lowest
// - selector defaults to keeping gain lowest, raising exposure first
// - white balance exists only on color variants
// - starting white balance first loads red, green and blue ratios with 1.5
// - then ratios tune so red and blue averages equal green average
// - white balance uses metering region statistics, once or continuous
// - metering region off image: no steering, but once mode still loads 1.5
// - default configuration disables every auto function at reset
// - factory startup set enables auto exposure after reset
// - auto exposure moves exposure within limits until gray average hits target
// - target ranges 50 to 205 at 8 bits and 800 to 3280 at 12 bits
module alwb_top (
   input  wire        I_CLK,
   input  wire        I_RST,
   input  wire        I_COLOR,
   input  wire        I_FACTORY_START,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        I_STAT_VALID,
   input  wire        I_REGION_OVERLAP,
   input  wire [11:0] I_AVG_GRAY,
   input  wire [11:0] I_AVG_RED,
   input  wire [11:0] I_AVG_GREEN,
   input  wire [11:0] I_AVG_BLUE,
   output reg  [15:0] O_EXPOSURE,
   output reg  [15:0] O_GAIN,
   output reg  [9:0]  O_RATIO_RED,
   output reg  [9:0]  O_RATIO_GREEN,
   output reg  [9:0]  O_RATIO_BLUE
);
   reg  [1:0]  auto_exposure_mode_reg;
   reg  [1:0]  auto_gain_mode_reg;
   reg  [1:0]  auto_white_balance_mode_reg;
   reg         keep_gain_lowest_reg;
   reg         bit12_reg;
   reg  [9:0]  damping_factor_raw_reg;
   reg  [11:0] target_reg;
   reg  [15:0] exp_lo_reg;
   reg  [15:0] exp_hi_reg;
   reg  [15:0] gain_lo_reg;
   reg  [15:0] gain_hi_reg;
   reg  [11:0] last_gray_reg;
   reg  [11:0] last_red_reg;
   reg  [11:0] last_blue_reg;
   reg         awb_loaded_reg;
   reg         started_reg;
   reg         err_reg;
   reg  [31:0] rdata_next;
   reg         err_next;
   reg         wr_ok;
   wire        setup    = PSEL & ~PENABLE;
   wire        exp_on   = auto_exposure_mode_reg != `ALWB_MODE_OFF;
   wire        gain_on  = auto_gain_mode_reg != `ALWB_MODE_OFF;
   wire        awb_on   = auto_white_balance_mode_reg != `ALWB_MODE_OFF;
   wire [11:0] tgt_min  = bit12_reg ? `ALWB_TGT12_MIN : `ALWB_TGT8_MIN;
   wire [11:0] tgt_max  = bit12_reg ? `ALWB_TGT12_MAX : `ALWB_TGT8_MAX;
   // a change of output width pulls the target into the new legal span
   wire        wr_bit12   = PWDATA[`ALWB_CTRL_BIT12];
   wire [11:0] wr_tgt_min = wr_bit12 ? `ALWB_TGT12_MIN : `ALWB_TGT8_MIN;
   wire [11:0] wr_tgt_max = wr_bit12 ? `ALWB_TGT12_MAX : `ALWB_TGT8_MAX;
   wire        gray_low = I_AVG_GRAY < target_reg;
   wire [12:0] gray_err = gray_low ? {1'b0, target_reg - I_AVG_GRAY}
                                   : {1'b0, I_AVG_GRAY - target_reg};
   wire        at_target = gray_err == 13'h0_000;
   wire [15:0] exp_step;
   wire [15:0] gain_step;
   // in mixed mode the kept-low quantity only rises once the other is pinned, and falls first
   wire        exp_pinned  = gray_low ? (O_EXPOSURE >= exp_hi_reg) : (O_EXPOSURE <= exp_lo_reg);
   wire        gain_pinned = gray_low ? (O_GAIN >= gain_hi_reg) : (O_GAIN <= gain_lo_reg);
   wire        gain_at_lo  = O_GAIN <= gain_lo_reg;
   wire        exp_at_lo   = O_EXPOSURE <= exp_lo_reg;
   reg         move_exp;
   reg         move_gain;
   always @* begin
      move_exp  = exp_on;
      move_gain = gain_on;
      if (exp_on && gain_on) begin
         if (keep_gain_lowest_reg) begin
            // brighten with exposure first, darken by dropping gain first
            move_exp  = gray_low ? 1'b1 : gain_at_lo;
            move_gain = gray_low ? exp_pinned : 1'b1;
         end else begin
            move_gain = gray_low ? 1'b1 : exp_at_lo;
            move_exp  = gray_low ? gain_pinned : 1'b1;
         end
      end
   end
   alwb_step u_exp_step (
      .i_cur     (O_EXPOSURE),
      .i_err     (gray_err),
      .i_err_neg (~gray_low),
      .i_damp    (damping_factor_raw_reg),
      .i_lo      (exp_lo_reg),
      .i_hi      (exp_hi_reg),
      .o_next    (exp_step)
   );
   alwb_step u_gain_step (
      .i_cur     (O_GAIN),
      .i_err     (gray_err),
      .i_err_neg (~gray_low),
      .i_damp    (damping_factor_raw_reg),
      .i_lo      (gain_lo_reg),
      .i_hi      (gain_hi_reg),
      .o_next    (gain_step)
   );
   // white balance: ratio moves by one count per frame toward equal averages
   // mono variants never steer, even if a mode was left on when the strap dropped
   wire        awb_allow = awb_loaded_reg & I_COLOR;
   wire        awb_steer = awb_allow & I_REGION_OVERLAP;
   // per-channel gray-world step: index 0 is red, 1 is blue; green is the reference
   wire [11:0] chan_avg   [0:1];
   wire [9:0]  chan_ratio [0:1];
   wire [9:0]  chan_next  [0:1];
   assign chan_avg[0]   = I_AVG_RED;
   assign chan_avg[1]   = I_AVG_BLUE;
   assign chan_ratio[0] = O_RATIO_RED;
   assign chan_ratio[1] = O_RATIO_BLUE;
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ratio
         wire rise = chan_avg[ch] < I_AVG_GREEN && chan_ratio[ch] != `ALWB_RATIO_MAX;
         wire fall = chan_avg[ch] > I_AVG_GREEN && chan_ratio[ch] != `ALWB_RATIO_MIN;
         assign chan_next[ch] = rise ? chan_ratio[ch] + `ALWB_RATIO_STEP
                              : fall ? chan_ratio[ch] - `ALWB_RATIO_STEP : chan_ratio[ch];
      end
   endgenerate
   wire [9:0]  red_next  = chan_next[0];
   wire [9:0]  blue_next = chan_next[1];
   wire        awb_match = I_AVG_RED == I_AVG_GREEN && I_AVG_BLUE == I_AVG_GREEN;
   // register read and write-legality decode
   always @* begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      wr_ok      = 1'b1;
      case (PADDR)
         `ALWB_ADDR_CTRL: begin
            rdata_next = {24'h00_0000, bit12_reg, keep_gain_lowest_reg,
                          auto_white_balance_mode_reg, auto_gain_mode_reg,
                          auto_exposure_mode_reg};
            if (PWDATA[`ALWB_CTRL_AWB_LSB+1:`ALWB_CTRL_AWB_LSB] != `ALWB_MODE_OFF && !I_COLOR)
               wr_ok = 1'b0;
         end
         `ALWB_ADDR_DAMP: begin
            rdata_next = {22'h00_0000, damping_factor_raw_reg};
            if (PWDATA > {22'h00_0000, `ALWB_DAMP_MAX})
               wr_ok = 1'b0;
         end
         `ALWB_ADDR_TARGET: begin
            rdata_next = {20'h0_0000, target_reg};
            if (PWDATA[31:12] != 20'h0_0000 || PWDATA[11:0] < tgt_min
                || PWDATA[11:0] > tgt_max)
               wr_ok = 1'b0;
         end
         `ALWB_ADDR_EXP_LIM: begin
            rdata_next = {exp_hi_reg, exp_lo_reg};
            if (PWDATA[15:0] > PWDATA[31:16])
               wr_ok = 1'b0;
         end
         `ALWB_ADDR_GAIN_LIM: begin
            rdata_next = {gain_hi_reg, gain_lo_reg};
            if (PWDATA[15:0] > PWDATA[31:16])
               wr_ok = 1'b0;
         end
         `ALWB_ADDR_STAT_GRAY: rdata_next = {20'h0_0000, last_gray_reg};
         `ALWB_ADDR_STAT_RB:   rdata_next = {4'h0, last_blue_reg, 4'h0, last_red_reg};
         `ALWB_ADDR_EXP_GAIN:  rdata_next = {O_GAIN, O_EXPOSURE};
         `ALWB_ADDR_RATIOS:    rdata_next = {2'b00, O_RATIO_BLUE, O_RATIO_GREEN, O_RATIO_RED};
         `ALWB_ADDR_STATUS:    rdata_next = {29'h0000_0000, I_COLOR, awb_loaded_reg, err_reg};
         default: begin
            err_next = 1'b1;
            wr_ok    = 1'b0;
         end
      endcase
      if (PWRITE && !wr_ok)
         err_next = 1'b1;
      if (!PWRITE)
         err_next = err_next & (PADDR[1:0] != 2'b00);
   end
   wire wr_en = setup & PWRITE & wr_ok;
   always @(posedge I_CLK) begin
      if (I_RST) begin
         PRDATA                      <= 32'h0000_0000;
         PREADY                      <= 1'b0;
         PSLVERR                     <= 1'b0;
         started_reg                 <= 1'b0;
         auto_exposure_mode_reg      <= `ALWB_MODE_OFF;
         auto_gain_mode_reg          <= `ALWB_MODE_OFF;
         auto_white_balance_mode_reg <= `ALWB_MODE_OFF;
         keep_gain_lowest_reg        <= 1'b1;
         bit12_reg                   <= 1'b0;
         damping_factor_raw_reg      <= `ALWB_DAMP_RST;
         target_reg                  <= `ALWB_TGT_RST;
         exp_lo_reg                  <= `ALWB_EXP_LO_RST;
         exp_hi_reg                  <= `ALWB_EXP_HI_RST;
         gain_lo_reg                 <= `ALWB_GAIN_LO_RST;
         gain_hi_reg                 <= `ALWB_GAIN_HI_RST;
         O_EXPOSURE                  <= `ALWB_EXP_LO_RST;
         O_GAIN                      <= `ALWB_GAIN_LO_RST;
         O_RATIO_RED                 <= `ALWB_RATIO_INIT;
         O_RATIO_GREEN               <= `ALWB_RATIO_INIT;
         O_RATIO_BLUE                <= `ALWB_RATIO_INIT;
         last_gray_reg               <= 12'h000;
         last_red_reg                <= 12'h000;
         last_blue_reg               <= 12'h000;
         awb_loaded_reg              <= 1'b0;
         err_reg                     <= 1'b0;
      end else begin
         // apb: no wait state, answer in the access cycle after setup
         PREADY  <= setup;
         PSLVERR <= setup & err_next;
         if (setup && !PWRITE)
            PRDATA <= rdata_next;
         if (setup && err_next)
            err_reg <= 1'b1;
         else if (wr_en && PADDR == `ALWB_ADDR_STATUS)
            err_reg <= 1'b0;
         // startup set caught once after reset release
         started_reg <= 1'b1;
         if (!started_reg && I_FACTORY_START)
            auto_exposure_mode_reg <= `ALWB_MODE_CONT;
         if (wr_en) begin
            case (PADDR)
               `ALWB_ADDR_CTRL: begin
                  auto_exposure_mode_reg <= PWDATA[`ALWB_CTRL_EXP_LSB+1:`ALWB_CTRL_EXP_LSB];
                  auto_gain_mode_reg     <= PWDATA[`ALWB_CTRL_GAIN_LSB+1:`ALWB_CTRL_GAIN_LSB];
                  auto_white_balance_mode_reg <=
                     PWDATA[`ALWB_CTRL_AWB_LSB+1:`ALWB_CTRL_AWB_LSB];
                  keep_gain_lowest_reg   <= PWDATA[`ALWB_CTRL_MIN_BIT];
                  bit12_reg              <= PWDATA[`ALWB_CTRL_BIT12];
                  if (target_reg < wr_tgt_min)
                     target_reg <= wr_tgt_min;
                  else if (target_reg > wr_tgt_max)
                     target_reg <= wr_tgt_max;
                  if (PWDATA[`ALWB_CTRL_AWB_LSB+1:`ALWB_CTRL_AWB_LSB] != `ALWB_MODE_OFF) begin
                     O_RATIO_RED    <= `ALWB_RATIO_INIT;
                     O_RATIO_GREEN  <= `ALWB_RATIO_INIT;
                     O_RATIO_BLUE   <= `ALWB_RATIO_INIT;
                     awb_loaded_reg <= 1'b1;
                  end else
                     awb_loaded_reg <= 1'b0;
               end
               `ALWB_ADDR_DAMP:     damping_factor_raw_reg <= PWDATA[9:0];
               `ALWB_ADDR_TARGET:   target_reg <= PWDATA[11:0];
               `ALWB_ADDR_EXP_LIM: begin
                  exp_lo_reg <= PWDATA[15:0];
                  exp_hi_reg <= PWDATA[31:16];
                  // new limits take hold at once, not at the next frame
                  if (O_EXPOSURE < PWDATA[15:0])
                     O_EXPOSURE <= PWDATA[15:0];
                  else if (O_EXPOSURE > PWDATA[31:16])
                     O_EXPOSURE <= PWDATA[31:16];
               end
               `ALWB_ADDR_GAIN_LIM: begin
                  gain_lo_reg <= PWDATA[15:0];
                  gain_hi_reg <= PWDATA[31:16];
                  if (O_GAIN < PWDATA[15:0])
                     O_GAIN <= PWDATA[15:0];
                  else if (O_GAIN > PWDATA[31:16])
                     O_GAIN <= PWDATA[31:16];
               end
               default: ;
            endcase
         end else if (I_STAT_VALID) begin
            // a register write in the same cycle wins and this frame is skipped
            last_gray_reg <= I_AVG_GRAY;
            last_red_reg  <= I_AVG_RED;
            last_blue_reg <= I_AVG_BLUE;
            if (I_REGION_OVERLAP) begin
               if (move_exp)
                  O_EXPOSURE <= exp_step;
               if (move_gain)
                  O_GAIN <= gain_step;
               if (at_target && auto_exposure_mode_reg == `ALWB_MODE_ONCE)
                  auto_exposure_mode_reg <= `ALWB_MODE_OFF;
               if (at_target && auto_gain_mode_reg == `ALWB_MODE_ONCE)
                  auto_gain_mode_reg <= `ALWB_MODE_OFF;
            end
            if (awb_on && awb_steer) begin
               O_RATIO_RED  <= red_next;
               O_RATIO_BLUE <= blue_next;
               if (awb_match && auto_white_balance_mode_reg == `ALWB_MODE_ONCE)
                  auto_white_balance_mode_reg <= `ALWB_MODE_OFF;
            end
         end
      end
   end
endmodule

// file: verification/alwb_asserts.sv
// Purpose: port-level checks for the auto level and white balance block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to alwb_top below the module
`timescale 1ns/10ps
module alwb_asserts (
   input wire        I_CLK,
   input wire        I_RST,
   input wire        I_COLOR,
   input wire        I_FACTORY_START,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire        I_STAT_VALID,
   input wire        I_REGION_OVERLAP,
   input wire [11:0] I_AVG_GRAY,
   input wire [11:0] I_AVG_RED,
   input wire [11:0] I_AVG_GREEN,
   input wire [11:0] I_AVG_BLUE,
   input wire [15:0] O_EXPOSURE,
   input wire [15:0] O_GAIN,
   input wire [9:0]  O_RATIO_RED,
   input wire [9:0]  O_RATIO_GREEN,
   input wire [9:0]  O_RATIO_BLUE
);
   wire              setup_wr;
   wire              frame_only;
   assign setup_wr = PSEL && !PENABLE && PWRITE;
   assign frame_only = I_STAT_VALID && !setup_wr;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("ready not one cycle after setup");
   a_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
      else $error("error flag outside access cycle");
   a_reset_levels: assert property (disable iff (1'b0) I_RST |=>
      O_EXPOSURE == 16'h0064 && O_GAIN == 16'h0000 && O_RATIO_GREEN == 10'h180)
      else $error("outputs not at reset levels");
   a_idle_hold: assert property (!I_STAT_VALID && !setup_wr |=>
      $stable(O_EXPOSURE) && $stable(O_GAIN))
      else $error("exposure or gain moved without a frame");
   a_overlap_gate: assert property (frame_only && !I_REGION_OVERLAP |=>
      $stable(O_EXPOSURE) && $stable(O_GAIN) && $stable(O_RATIO_RED) &&
      $stable(O_RATIO_BLUE))
      else $error("steering from region off image");
   a_green_fixed: assert property (frame_only |=> $stable(O_RATIO_GREEN))
      else $error("green ratio moved on a frame");
   a_ratio_unit_step: assert property (frame_only |=>
      O_RATIO_RED == $past(O_RATIO_RED) || O_RATIO_RED == $past(O_RATIO_RED) + 10'h1 ||
      O_RATIO_RED == $past(O_RATIO_RED) - 10'h1)
      else $error("red ratio step larger than one");
   a_mono_no_wb: assert property (frame_only && !I_COLOR |=>
      $stable(O_RATIO_RED) && $stable(O_RATIO_BLUE))
      else $error("white balance active on mono variant");
endmodule

bind alwb_top alwb_asserts u_alwb_asserts (.I_CLK(I_CLK), .I_RST(I_RST), .I_COLOR(I_COLOR),
   .I_FACTORY_START(I_FACTORY_START), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .I_STAT_VALID(I_STAT_VALID), .I_REGION_OVERLAP(I_REGION_OVERLAP),
   .I_AVG_GRAY(I_AVG_GRAY), .I_AVG_RED(I_AVG_RED), .I_AVG_GREEN(I_AVG_GREEN),
   .I_AVG_BLUE(I_AVG_BLUE), .O_EXPOSURE(O_EXPOSURE), .O_GAIN(O_GAIN),
   .O_RATIO_RED(O_RATIO_RED), .O_RATIO_GREEN(O_RATIO_GREEN), .O_RATIO_BLUE(O_RATIO_BLUE));

// file: verification/alwb_top_bench.sv
// Purpose: self-checking bench for the auto level and white balance block
// Assumes: APB slave answers one cycle after setup, frame pulse one cycle
// Notes:   step per frame is error times raw damping over 1024
`timescale 1ns/10ps
`include "alwb_defines.vh"
module alwb_top_bench;
   logic        I_CLK, I_RST, I_COLOR, I_FACTORY_START, PSEL, PENABLE, PWRITE;
   logic        I_STAT_VALID, I_REGION_OVERLAP, rerr;
   logic [11:0] PADDR, I_AVG_GRAY, I_AVG_RED, I_AVG_GREEN, I_AVG_BLUE;
   logic [31:0] PWDATA, rdata;
   wire  [31:0] PRDATA;
   wire         PREADY, PSLVERR;
   wire  [15:0] O_EXPOSURE, O_GAIN;
   wire  [9:0]  O_RATIO_RED, O_RATIO_GREEN, O_RATIO_BLUE;
   int          failures = 0;
   int          comparisons = 0;
   alwb_top u_alwb_top (.I_CLK(I_CLK), .I_RST(I_RST), .I_COLOR(I_COLOR),
      .I_FACTORY_START(I_FACTORY_START), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .I_STAT_VALID(I_STAT_VALID), .I_REGION_OVERLAP(I_REGION_OVERLAP),
      .I_AVG_GRAY(I_AVG_GRAY), .I_AVG_RED(I_AVG_RED), .I_AVG_GREEN(I_AVG_GREEN),
      .I_AVG_BLUE(I_AVG_BLUE), .O_EXPOSURE(O_EXPOSURE), .O_GAIN(O_GAIN),
      .O_RATIO_RED(O_RATIO_RED), .O_RATIO_GREEN(O_RATIO_GREEN), .O_RATIO_BLUE(O_RATIO_BLUE));
   initial begin
      I_CLK = 1'b0;
      forever #25 I_CLK = ~I_CLK;
   end
   task automatic close_out;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge I_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge I_CLK);
      PENABLE <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge I_CLK);
         if (PREADY === 1'b1) break;
      end
      rdata = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n == 20) begin
         failures++;
         close_out();
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, rerr}, {31'h0, e});
   endtask
   task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk({31'h0, rerr}, 32'h0);
      chk(rdata, exp);
   endtask
   // one frame of statistics, outputs settled on return
   task automatic frame(input logic [11:0] g, input logic [11:0] r, input logic [11:0] b,
                        input logic ov);
      @(posedge I_CLK);
      I_STAT_VALID <= 1'b1;
      I_AVG_GRAY <= g;
      I_AVG_RED <= r;
      I_AVG_GREEN <= 12'h064;
      I_AVG_BLUE <= b;
      I_REGION_OVERLAP <= ov;
      @(posedge I_CLK);
      I_STAT_VALID <= 1'b0;
      @(posedge I_CLK);
   endtask
   task automatic rst(input logic fs);
      @(posedge I_CLK);
      I_FACTORY_START <= fs;
      I_RST <= 1'b1;
      repeat (5) @(posedge I_CLK);
      I_RST <= 1'b0;
   endtask
   task automatic ratios(input logic [9:0] r, input logic [9:0] b);
      chk(O_RATIO_RED, r);
      chk(O_RATIO_GREEN, 10'h180);
      chk(O_RATIO_BLUE, b);
   endtask
   initial begin
      repeat (100000) @(posedge I_CLK);
      failures++;
      close_out();
   end
   initial begin
      {I_FACTORY_START, PSEL, PENABLE, PWRITE, I_STAT_VALID} <= 5'h00;
      {I_RST, I_COLOR, I_REGION_OVERLAP} <= 3'h7;
      {PADDR, I_AVG_GRAY, I_AVG_RED, I_AVG_GREEN, I_AVG_BLUE, PWDATA} <= 92'h0;
      rst(1'b0);
      rreg(`ALWB_ADDR_CTRL, 32'h0000_0040);
      rreg(`ALWB_ADDR_DAMP, 32'h0000_02BC);
      chk(O_EXPOSURE, 16'h0064);
      $display("test reset values done");
      wreg(`ALWB_ADDR_DAMP, 32'h0000_0321, 1'b1);
      rreg(`ALWB_ADDR_DAMP, 32'h0000_02BC);
      wreg(`ALWB_ADDR_DAMP, 32'h0000_0320, 1'b0);
      rreg(`ALWB_ADDR_DAMP, 32'h0000_0320);
      wreg(`ALWB_ADDR_DAMP, 32'h0000_02BC, 1'b0);
      wreg(12'h028, 32'h0000_0001, 1'b1);
      rreg(`ALWB_ADDR_STATUS, 32'h0000_0005);
      wreg(`ALWB_ADDR_STATUS, 32'h0000_0000, 1'b0);
      rreg(`ALWB_ADDR_STATUS, 32'h0000_0004);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0031, 1'b1);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0032, 1'b0);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0080, 1'b0);
      wreg(`ALWB_ADDR_CTRL, 32'h0000_00C0, 1'b0);
      rreg(`ALWB_ADDR_TARGET, 32'h0000_0320);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0CD1, 1'b1);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0CD0, 1'b0);
      wreg(`ALWB_ADDR_CTRL, 32'h0000_0040, 1'b0);
      rreg(`ALWB_ADDR_TARGET, 32'h0000_00CD);
      wreg(`ALWB_ADDR_TARGET, 32'h0000_0080, 1'b0);
      $display("test damping and target limits done");
      wreg(`ALWB_ADDR_CTRL, 32'h0000_0042, 1'b0);
      frame(12'h01C, 12'h064, 12'h064, 1'b1);
      chk(O_EXPOSURE, 16'h00A8);
      frame(12'h01C, 12'h064, 12'h064, 1'b0);
      chk(O_EXPOSURE, 16'h00A8);
      wreg(`ALWB_ADDR_DAMP, 32'h0000_0200, 1'b0);
      frame(12'h01C, 12'h064, 12'h064, 1'b1);
      chk(O_EXPOSURE, 16'h00DA);
      wreg(`ALWB_ADDR_EXP_LIM, 32'h00E0_0064, 1'b0);
      frame(12'h01C, 12'h064, 12'h064, 1'b1);
      chk(O_EXPOSURE, 16'h00E0);
      $display("test exposure loop done");
      wreg(`ALWB_ADDR_EXP_LIM, 32'hFFFF_0064, 1'b0);
      wreg(`ALWB_ADDR_CTRL, 32'h0000_004A, 1'b0);
      frame(12'h01C, 12'h064, 12'h064, 1'b1);
      chk(O_EXPOSURE, 16'h0112);
      chk(O_GAIN, 16'h0000);
      wreg(`ALWB_ADDR_CTRL, 32'h0000_000A, 1'b0);
      frame(12'h01C, 12'h064, 12'h064, 1'b1);
      chk(O_EXPOSURE, 16'h0112);
      chk(O_GAIN, 16'h0032);
      wreg(`ALWB_ADDR_GAIN_LIM, 32'h0010_0000, 1'b0);
      chk(O_GAIN, 16'h0010);
      $display("test gain profile done");
      wreg(`ALWB_ADDR_CTRL, 32'h0000_0060, 1'b0);
      frame(12'h01C, 12'h05A, 12'h06E, 1'b1);
      ratios(10'h181, 10'h17F);
      frame(12'h01C, 12'h05A, 12'h06E, 1'b0);
      ratios(10'h181, 10'h17F);
      wreg(`ALWB_ADDR_CTRL, 32'h0000_0050, 1'b0);
      ratios(10'h180, 10'h180);
      @(posedge I_CLK);
      I_COLOR <= 1'b0;
      wreg(`ALWB_ADDR_CTRL, 32'h0000_0060, 1'b1);
      frame(12'h01C, 12'h05A, 12'h06E, 1'b1);
      ratios(10'h180, 10'h180);
      I_COLOR <= 1'b1;
      $display("test white balance done");
      rst(1'b1);
      rreg(`ALWB_ADDR_CTRL, 32'h0000_0042);
      rst(1'b0);
      rreg(`ALWB_ADDR_CTRL, 32'h0000_0040);
      $display("test startup sets done");
      close_out();
   end
endmodule
